/* hdl/svm_pkg.sv */
package svm_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W         = 12;
	localparam logic [11:0] OFF_STATUS     = 12'h000;
	localparam logic [11:0] OFF_CONFIG     = 12'h004;
	localparam logic [11:0] OFF_EVT_STATUS = 12'h008;
	localparam logic [11:0] OFF_EVT_MASK   = 12'h00C;

	// ----------------------------------------------------------------
	// Monitor status register fields
	// ----------------------------------------------------------------
	localparam int unsigned ST_IND_BIT  = 7;
	localparam int unsigned ST_IE_BIT   = 2;
	localparam int unsigned ST_FLAG_BIT = 1;
	localparam int unsigned ST_ACK_BIT  = 0;

	// ----------------------------------------------------------------
	// Configuration register fields and reset values
	// ----------------------------------------------------------------
	localparam int unsigned CFG_PWR_DIS_BIT  = 0;
	localparam int unsigned CFG_RST_DIS_BIT  = 1;
	localparam int unsigned CFG_STOP_EN_BIT  = 2;
	localparam int unsigned CFG_SEL_LSB      = 4;
	localparam int unsigned SEL_W            = 2;
	localparam logic        CFG_PWR_DIS_RST  = 1'h1;
	localparam logic        CFG_RST_DIS_RST  = 1'h0;
	localparam logic        CFG_STOP_EN_RST  = 1'h0;
	localparam logic [1:0]  CFG_SEL_RST      = 2'h1;
	localparam logic [1:0]  LEVEL_5V         = 2'h1;
	localparam logic [1:0]  LEVEL_3V3        = 2'h2;

	// ----------------------------------------------------------------
	// Event status and mask fields
	// ----------------------------------------------------------------
	localparam int unsigned EVT_W          = 2;
	localparam int unsigned EVT_CHANGE_BIT = 0;
	localparam int unsigned EVT_RESET_BIT  = 1;

	// ----------------------------------------------------------------
	// Synchroniser depth
	// ----------------------------------------------------------------
	localparam int unsigned SYNC_STAGES = 2;

	typedef enum logic [1:0] {
		MON_OFF,
		MON_WATCH,
		MON_HOLD
	} svm_mon_t;

	function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] off);
		addr_hit = (addr[11:2] == off[11:2]);
	endfunction

endpackage

/* hdl/svm_sync.sv */
`timescale 1ns/1ps
module svm_sync #(
	parameter int unsigned WIDTH = 2
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] held;
	} svm_sync_t;

	svm_sync_t s_r;
	svm_sync_t s_nxt;

	if (WIDTH < 1) begin : g_chk
		$error("svm_sync: WIDTH must be at least 1");
	end

	always_comb begin
		s_nxt      = s_r;
		s_nxt.meta = din;
		s_nxt.held = s_r.meta;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign dout = s_r.held;

endmodule

/* hdl/svm_apb_slave.sv */
`timescale 1ns/1ps
module svm_apb_slave #(
	parameter int unsigned ADDR_W = svm_pkg::ADDR_W
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       rd_data,
	input  wire logic              addr_ok,
	output logic                   wr_en,
	output logic                   pready,
	output logic      [31:0]       prdata,
	output logic                   pslverr
);

	typedef struct packed {
		logic        ready;
		logic [31:0] rdata;
		logic        err;
	} svm_apb_t;

	svm_apb_t s_r;
	svm_apb_t s_nxt;

	if (ADDR_W < 4) begin : g_chk
		$error("svm_apb_slave: ADDR_W must be at least 4");
	end

	// ----------------------------------------------------------------
	// One wait state: ready rises on the second access cycle
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt       = s_r;
		s_nxt.ready = 1'b0;
		s_nxt.err   = 1'b0;
		s_nxt.rdata = 32'h0000_0000;
		if (psel && penable && !s_r.ready) begin
			s_nxt.ready = 1'b1;
			s_nxt.err   = !addr_ok;
			s_nxt.rdata = (pwrite || !addr_ok) ? 32'h0000_0000 : rd_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Write lands on the completing edge only
	assign wr_en   = psel && penable && pwrite && s_r.ready && addr_ok;
	assign pready  = s_r.ready;
	assign prdata  = s_r.rdata;
	assign pslverr = s_r.err;

endmodule

/* hdl/svm_monitor_ctrl.sv */
// How it works
// RULE1: Monitor is off after reset; it runs only once power-disable is cleared.
// RULE2: With reset generation enabled and monitoring on, a falling trip causes chip reset.
// RULE3: Stop-mode enable keeps the monitor running in stop; otherwise it idles there.
// RULE4: A two-bit field selects the 5V or 3.3V falling trip threshold.
// RULE5: Indication is 0 above rising level, 1 below falling level, else held.
// RULE6: Every change of the indication, either direction, sets the change flag.
// RULE7: CPU interrupt is raised while change flag and its enable are both set.
// RULE8: Writing 1 to acknowledge clears the flag; 0 does nothing; it reads 0.
// RULE9: Reset clears enable and flag; enable is read/write, flag read and ack-clear.
// RULE10: Reset beats interrupt on a trip and clears the interrupt enable.
// RULE11: A triggered reset is held until the supply rises above the rising level.
// RULE12: An undervoltage reset also pulls the external active-low reset pin low.
// RULE13: Software wanting interrupts only keeps power-disable 0 and reset-disable 1.
// RULE14: The monitor stays active in wait mode and can wake by reset or interrupt.
// RULE15: With stop enable set it stays active in stop and can wake the chip.
// RULE16: Enabling while already below the 3.3V falling level resets at once.
// RULE17: Software sets the trip level before clearing power-disable.
// RULE18: Comparator outputs are synchronised before any toggle detection.
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
module svm_monitor_ctrl #(
	parameter int unsigned ADDR_W = svm_pkg::ADDR_W
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic      [31:0]       prdata,
	output logic                   pslverr,
	input  wire logic              cmp_below_falling,
	input  wire logic              cmp_above_rising,
	input  wire logic              wait_mode,
	input  wire logic              stop_mode,
	output logic                   cmp_enable,
	output logic      [1:0]        cmp_level_sel,
	output logic                   chip_reset_req,
	output logic                   ext_reset_n,
	output logic                   cpu_irq,
	output logic                   irq,
	output logic                   wake_req
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		svm_pkg::svm_mon_t               state;
		logic                            ind;
		logic                            flag;
		logic                            ie;
		logic                            pwr_dis;
		logic                            rst_dis;
		logic                            stop_en;
		logic [svm_pkg::SEL_W-1:0]       sel;
		logic [svm_pkg::SYNC_STAGES-1:0] warm;
		logic [svm_pkg::EVT_W-1:0]       evt;
		logic [svm_pkg::EVT_W-1:0]       mask;
		logic                            cmp_en;
		logic                            chip_rst;
		logic                            ext_rst_n;
		logic                            cpu_irq;
		logic                            irq;
		logic                            wake;
	} svm_state_t;

	svm_state_t s_r;
	svm_state_t s_nxt;

	logic [1:0]  cmp_sync;
	logic        below;
	logic        above;
	logic        wr_en;
	logic        addr_ok;
	logic [31:0] rd_data;
	logic [11:0] addr;
	logic [3:0]  rsel;

	if (ADDR_W > 12 || ADDR_W < 4) begin : g_chk
		$error("svm_monitor_ctrl: ADDR_W must lie between 4 and 12");
	end

	if (svm_pkg::SYNC_STAGES < 2) begin : g_sync_chk
		$error("svm_monitor_ctrl: SYNC_STAGES must be at least 2");
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [3:0] reg_sel(input logic [11:0] a);
		reg_sel = 4'h0;
		if (svm_pkg::addr_hit(a, svm_pkg::OFF_STATUS)) begin
			reg_sel = 4'h1;
		end else if (svm_pkg::addr_hit(a, svm_pkg::OFF_CONFIG)) begin
			reg_sel = 4'h2;
		end else if (svm_pkg::addr_hit(a, svm_pkg::OFF_EVT_STATUS)) begin
			reg_sel = 4'h4;
		end else if (svm_pkg::addr_hit(a, svm_pkg::OFF_EVT_MASK)) begin
			reg_sel = 4'h8;
		end
	endfunction

	// Sticky bit: a set in the clearing cycle wins
	function automatic logic sticky_bit(input logic cur, input logic clr, input logic set);
		sticky_bit = (cur && !clr) || set;
	endfunction

	assign addr = {{(12 - ADDR_W){1'b0}}, paddr};
	assign rsel = reg_sel(addr);

	// ----------------------------------------------------------------
	// Comparator synchronisation
	// ----------------------------------------------------------------
	svm_sync #(
		.WIDTH (2)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.din     ({cmp_above_rising, cmp_below_falling}),
		.dout    (cmp_sync)
	);

	assign below = cmp_sync[0]; // RULE18
	assign above = cmp_sync[1]; // RULE18

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	svm_apb_slave #(
		.ADDR_W (ADDR_W)
	) u_apb (
		.pclk    (pclk),
		.presetn (presetn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.rd_data (rd_data),
		.addr_ok (addr_ok),
		.wr_en   (wr_en),
		.pready  (pready),
		.prdata  (prdata),
		.pslverr (pslverr)
	);

	// ----------------------------------------------------------------
	// Read decode
	// ----------------------------------------------------------------
	always_comb begin
		rd_data = 32'h0000_0000;
		addr_ok = 1'b1;
		if (rsel[0]) begin
			rd_data[svm_pkg::ST_IND_BIT]  = s_r.ind;
			rd_data[svm_pkg::ST_IE_BIT]   = s_r.ie;
			rd_data[svm_pkg::ST_FLAG_BIT] = s_r.flag;
			rd_data[svm_pkg::ST_ACK_BIT]  = 1'b0; // RULE8
		end else if (rsel[1]) begin
			rd_data[svm_pkg::CFG_PWR_DIS_BIT] = s_r.pwr_dis;
			rd_data[svm_pkg::CFG_RST_DIS_BIT] = s_r.rst_dis;
			rd_data[svm_pkg::CFG_STOP_EN_BIT] = s_r.stop_en;
			rd_data[svm_pkg::CFG_SEL_LSB +: svm_pkg::SEL_W] = s_r.sel;
		end else if (rsel[2]) begin
			rd_data[svm_pkg::EVT_W-1:0] = s_r.evt;
		end else if (rsel[3]) begin
			rd_data[svm_pkg::EVT_W-1:0] = s_r.mask;
		end else begin
			addr_ok = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic                      active;
		logic                      ack;
		logic                      toggle;
		logic                      hold;
		logic                      trip;
		logic                      sense;
		logic [svm_pkg::EVT_W-1:0] evt_clr;
		logic [svm_pkg::EVT_W-1:0] evt_set;

		active  = 1'b0;
		ack     = 1'b0;
		toggle  = 1'b0;
		hold    = 1'b0;
		trip    = 1'b0;
		sense   = 1'b0;
		evt_clr = '0;
		evt_set = '0;
		s_nxt   = s_r;

		// Register writes
		if (wr_en) begin
			if (rsel[0]) begin
				s_nxt.ie = pwdata[svm_pkg::ST_IE_BIT]; // RULE9
				ack      = pwdata[svm_pkg::ST_ACK_BIT]; // RULE8
			end else if (rsel[1]) begin
				s_nxt.pwr_dis = pwdata[svm_pkg::CFG_PWR_DIS_BIT];
				s_nxt.rst_dis = pwdata[svm_pkg::CFG_RST_DIS_BIT];
				s_nxt.stop_en = pwdata[svm_pkg::CFG_STOP_EN_BIT];
				s_nxt.sel     = pwdata[svm_pkg::CFG_SEL_LSB +: svm_pkg::SEL_W]; // RULE4
			end else if (rsel[2]) begin
				evt_clr = pwdata[svm_pkg::EVT_W-1:0];
			end else if (rsel[3]) begin
				s_nxt.mask = pwdata[svm_pkg::EVT_W-1:0];
			end
		end

		// Monitor runs unless powered down, and in stop only when allowed
		active = !s_r.pwr_dis && (!stop_mode || s_r.stop_en); // RULE1 RULE3 RULE14 RULE15

		// A freshly powered comparator still shows its off-state output in the
		// synchroniser, so its result is trusted only once that has drained
		if (s_r.cmp_en) begin
			s_nxt.warm = {s_r.warm[svm_pkg::SYNC_STAGES-2:0], 1'b1}; // RULE18
		end else begin
			s_nxt.warm = '0;
		end
		sense = active && s_r.warm[svm_pkg::SYNC_STAGES-1]; // RULE18

		// Indication with hysteresis
		if (sense) begin
			if (below) begin
				s_nxt.ind = 1'b1; // RULE5
			end else if (above) begin
				s_nxt.ind = 1'b0; // RULE5
			end
		end
		toggle = (s_nxt.ind != s_r.ind); // RULE6

		// Change flag: a toggle in the acknowledge cycle still sets it
		s_nxt.flag = sticky_bit(s_r.flag, ack, toggle); // RULE6 RULE8

		// Reset generation
		trip = sense && !s_r.rst_dis && below; // RULE2 RULE16
		case (s_r.state)
			svm_pkg::MON_OFF: begin
				if (trip) begin
					s_nxt.state = svm_pkg::MON_HOLD; // RULE16
				end else if (active) begin
					s_nxt.state = svm_pkg::MON_WATCH;
				end
			end
			svm_pkg::MON_WATCH: begin
				if (trip) begin
					s_nxt.state = svm_pkg::MON_HOLD; // RULE2
				end else if (!active) begin
					s_nxt.state = svm_pkg::MON_OFF;
				end
			end
			svm_pkg::MON_HOLD: begin
				if (above && s_r.warm[svm_pkg::SYNC_STAGES-1]) begin
					s_nxt.state = active ? svm_pkg::MON_WATCH : svm_pkg::MON_OFF; // RULE11
				end
			end
			default: begin
				s_nxt.state = svm_pkg::MON_OFF;
			end
		endcase
		hold = (s_nxt.state == svm_pkg::MON_HOLD);

		// Reset wins over interrupt
		if (hold) begin
			s_nxt.ie = 1'b0; // RULE10
		end

		// Sticky events, set wins over clear
		evt_set[svm_pkg::EVT_CHANGE_BIT] = toggle;
		evt_set[svm_pkg::EVT_RESET_BIT]  = hold && (s_r.state != svm_pkg::MON_HOLD);
		for (int i = 0; i < svm_pkg::EVT_W; i++) begin
			s_nxt.evt[i] = sticky_bit(s_r.evt[i], evt_clr[i], evt_set[i]);
		end

		// Outputs
		// Comparator stays powered while holding so that the release can be seen
		s_nxt.cmp_en    = active || hold; // RULE11
		s_nxt.chip_rst  = hold; // RULE2 RULE11
		s_nxt.ext_rst_n = !hold; // RULE12
		s_nxt.cpu_irq   = s_nxt.flag && s_nxt.ie && !hold; // RULE7 RULE10
		s_nxt.irq       = |(s_nxt.evt & s_nxt.mask);
		s_nxt.wake      = (wait_mode || stop_mode) && (s_nxt.cpu_irq || hold); // RULE14 RULE15
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r.state     <= svm_pkg::MON_OFF;
			s_r.ind       <= 1'b0; // RULE5
			s_r.flag      <= 1'b0; // RULE9
			s_r.ie        <= 1'b0; // RULE9
			s_r.pwr_dis   <= svm_pkg::CFG_PWR_DIS_RST; // RULE1
			s_r.rst_dis   <= svm_pkg::CFG_RST_DIS_RST;
			s_r.stop_en   <= svm_pkg::CFG_STOP_EN_RST;
			s_r.sel       <= svm_pkg::CFG_SEL_RST;
			s_r.evt       <= '0;
			s_r.mask      <= '0;
			s_r.warm      <= '0;
			s_r.cmp_en    <= 1'b0;
			s_r.chip_rst  <= 1'b0;
			s_r.ext_rst_n <= 1'b1;
			s_r.cpu_irq   <= 1'b0;
			s_r.irq       <= 1'b0;
			s_r.wake      <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign cmp_enable     = s_r.cmp_en;
	assign cmp_level_sel  = s_r.sel;
	assign chip_reset_req = s_r.chip_rst;
	assign ext_reset_n    = s_r.ext_rst_n;
	assign cpu_irq        = s_r.cpu_irq;
	assign irq            = s_r.irq;
	assign wake_req       = s_r.wake;

endmodule

/* verification/svm_monitor_ctrl_properties.sv */
`timescale 1ns/1ps
module svm_monitor_ctrl_chk (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic        cmp_above_rising,
	input wire logic        wait_mode,
	input wire logic        stop_mode,
	input wire logic        cmp_enable,
	input wire logic        chip_reset_req,
	input wire logic        ext_reset_n,
	input wire logic        cpu_irq,
	input wire logic        wake_req
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_apb_wait: assert property (
		psel && penable && !$past(penable) |-> !pready ##1 pready) else $error("access not one wait state");
	a_ready_pulse: assert property (
		pready |=> !pready) else $error("ready longer than one cycle");
	a_err_zero: assert property (
		pslverr |-> pready && prdata == 32'h0) else $error("error response malformed");
	a_idle_data: assert property (
		!pready |-> prdata == 32'h0) else $error("read data outside ready cycle");
	a_pin_level: assert property (
		ext_reset_n != chip_reset_req) else $error("reset pin disagrees with hold");
	a_irq_yield: assert property (
		cpu_irq |-> !chip_reset_req) else $error("interrupt during reset hold");
	a_wake_mode: assert property (
		wake_req |-> $past(wait_mode || stop_mode)) else $error("wake outside low power mode");
	a_trip_enabled: assert property (
		$rose(chip_reset_req) |-> cmp_enable) else $error("trip while monitor off");
	a_hold_release: assert property (
		$fell(chip_reset_req) |-> $past(cmp_above_rising, 3)) else $error("hold left without rising level");

	c_reset_hold: cover property ($rose(chip_reset_req));
	c_cpu_irq: cover property ($rose(cpu_irq));
	c_wake: cover property ($rose(wake_req));
	c_unmapped: cover property (pslverr);
endmodule

bind svm_monitor_ctrl svm_monitor_ctrl_chk u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
	.prdata(prdata), .pslverr(pslverr), .cmp_above_rising(cmp_above_rising),
	.wait_mode(wait_mode), .stop_mode(stop_mode), .cmp_enable(cmp_enable),
	.chip_reset_req(chip_reset_req), .ext_reset_n(ext_reset_n), .cpu_irq(cpu_irq), .wake_req(wake_req)
);

/* verification/svm_supply_model.sv */
`timescale 1ns/1ps
module svm_supply_model #(
	parameter int FALL_5V_MV  = 4200,
	parameter int FALL_3V3_MV = 2700,
	parameter int HYS_MV      = 150
) (
	input  wire logic        pclk,
	input  wire logic        cmp_enable,
	input  wire logic [1:0]  cmp_level_sel,
	input  wire logic [15:0] supply_mv,
	output logic             cmp_below_falling,
	output logic             cmp_above_rising
);
	logic junk = 1'b0;
	int   fall;

	// Powered-down comparator gives a changing pattern, never a clean level
	always @(posedge pclk) begin
		junk <= ~junk;
	end

	always_comb begin
		fall = (cmp_level_sel == svm_pkg::LEVEL_3V3) ? FALL_3V3_MV : FALL_5V_MV;
		cmp_below_falling = cmp_enable ? (int'(supply_mv) < fall) : junk;
		cmp_above_rising  = cmp_enable ? (int'(supply_mv) > fall + HYS_MV) : junk;
	end
endmodule

/* verification/tb_svm_monitor_ctrl.sv */
`timescale 1ns/1ps
module tb_svm_monitor_ctrl;
	logic        pclk, presetn, psel, penable, pwrite, wait_mode, stop_mode, err;
	logic        pready, pslverr, cmp_below_falling, cmp_above_rising, cmp_enable;
	logic        chip_reset_req, ext_reset_n, cpu_irq, irq, wake_req;
	logic [1:0]  cmp_level_sel;
	logic [11:0] paddr;
	logic [15:0] supply_mv;
	logic [31:0] pwdata, prdata, d;
	int          err_total, compares;

	svm_monitor_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.cmp_below_falling(cmp_below_falling), .cmp_above_rising(cmp_above_rising), .wait_mode(wait_mode),
		.stop_mode(stop_mode), .cmp_enable(cmp_enable), .cmp_level_sel(cmp_level_sel),
		.chip_reset_req(chip_reset_req), .ext_reset_n(ext_reset_n), .cpu_irq(cpu_irq), .irq(irq),
		.wake_req(wake_req));
	svm_supply_model u_supply (.pclk(pclk), .cmp_enable(cmp_enable), .cmp_level_sel(cmp_level_sel),
		.supply_mv(supply_mv), .cmp_below_falling(cmp_below_falling), .cmp_above_rising(cmp_above_rising));

	initial pclk = 1'b0;
	always #2 pclk = ~pclk;

	task final_report;
		if (err_total == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// ----------------------------------------------------------------
	// APB master
	// ----------------------------------------------------------------
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 16) begin
			@(posedge pclk);
			n++;
		end
		if (n == 16) begin
			err_total++;
			final_report;
		end
		d   = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [11:0] a, input logic [31:0] v);
		xfer(1'b1, a, v);
	endtask

	task rd(input logic [11:0] a, input logic [31:0] exp, input string what);
		xfer(1'b0, a, 32'h0);
		chk(what, d, exp);
	endtask

	task settle;
		repeat (6) @(posedge pclk);
	endtask

	initial begin
		#80000;
		err_total++;
		final_report;
	end

	initial begin
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
		wait_mode = 1'b0; stop_mode = 1'b0; supply_mv = 16'h1388; err_total = 0; compares = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rd(svm_pkg::OFF_STATUS, 32'h0, "status_reset");
		rd(svm_pkg::OFF_CONFIG, 32'h11, "config_reset");
		chk("cmp_enable_reset", cmp_enable, 32'h0);
		xfer(1'b0, 12'h010, 32'h0);
		chk("unmapped_err", err, 32'h1);
		chk("unmapped_data", d, 32'h0);
		// ----------------------------------------------------------------
		// Interrupt-only monitoring at the 5V level
		// ----------------------------------------------------------------
		wr(svm_pkg::OFF_CONFIG, 32'h13);
		wr(svm_pkg::OFF_CONFIG, 32'h12);
		wr(svm_pkg::OFF_STATUS, 32'h4);
		settle;
		chk("cmp_enable_on", cmp_enable, 32'h1);
		chk("level_5v", cmp_level_sel, svm_pkg::LEVEL_5V);
		supply_mv <= 16'h07D0;
		settle;
		rd(svm_pkg::OFF_STATUS, 32'h86, "drop_status");
		chk("irq_on_drop", cpu_irq, 32'h1);
		chk("no_reset_when_disabled", chip_reset_req, 32'h0);
		supply_mv <= 16'h109A;
		settle;
		rd(svm_pkg::OFF_STATUS, 32'h86, "band_hold");
		wr(svm_pkg::OFF_STATUS, 32'h5);
		rd(svm_pkg::OFF_STATUS, 32'h84, "ack_clear");
		chk("irq_after_ack", cpu_irq, 32'h0);
		supply_mv <= 16'h1388;
		settle;
		rd(svm_pkg::OFF_STATUS, 32'h06, "rise_status");
		wr(svm_pkg::OFF_STATUS, 32'h4);
		rd(svm_pkg::OFF_STATUS, 32'h06, "ack_zero");
		rd(svm_pkg::OFF_EVT_STATUS, 32'h1, "evt_toggle");
		chk("irq_masked", irq, 32'h0);
		wr(svm_pkg::OFF_EVT_MASK, 32'h1);
		repeat (2) @(posedge pclk);
		chk("irq_unmasked", irq, 32'h1);
		wr(svm_pkg::OFF_EVT_STATUS, 32'h1);
		rd(svm_pkg::OFF_EVT_STATUS, 32'h0, "evt_w1c");
		chk("irq_cleared", irq, 32'h0);
		wr(svm_pkg::OFF_STATUS, 32'h5);
		// ----------------------------------------------------------------
		// Wake from wait, freeze and wake in stop
		// ----------------------------------------------------------------
		wait_mode <= 1'b1;
		supply_mv <= 16'h07D0;
		settle;
		chk("wake_wait", wake_req, 32'h1);
		wr(svm_pkg::OFF_STATUS, 32'h5);
		repeat (2) @(posedge pclk);
		chk("wake_wait_ack", wake_req, 32'h0);
		wait_mode <= 1'b0;
		stop_mode <= 1'b1;
		supply_mv <= 16'h1388;
		settle;
		rd(svm_pkg::OFF_STATUS, 32'h84, "stop_frozen");
		chk("no_wake_stop", wake_req, 32'h0);
		wr(svm_pkg::OFF_CONFIG, 32'h16);
		settle;
		rd(svm_pkg::OFF_STATUS, 32'h06, "stop_active");
		chk("wake_stop", wake_req, 32'h1);
		stop_mode <= 1'b0;
		wr(svm_pkg::OFF_STATUS, 32'h5);
		// ----------------------------------------------------------------
		// Reset generation at the 3.3V level, enabled while already low
		// ----------------------------------------------------------------
		supply_mv <= 16'h07D0;
		wr(svm_pkg::OFF_CONFIG, 32'h21);
		wr(svm_pkg::OFF_CONFIG, 32'h20);
		settle;
		chk("hold_at_once", chip_reset_req, 32'h1);
		chk("pin_low", ext_reset_n, 32'h0);
		chk("irq_yields", cpu_irq, 32'h0);
		chk("level_3v3", cmp_level_sel, svm_pkg::LEVEL_3V3);
		rd(svm_pkg::OFF_STATUS, 32'h82, "ie_cleared");
		xfer(1'b0, svm_pkg::OFF_EVT_STATUS, 32'h0);
		chk("evt_hold", d[1], 32'h1);
		supply_mv <= 16'h0ABE;
		settle;
		chk("hold_in_band", chip_reset_req, 32'h1);
		supply_mv <= 16'h1388;
		settle;
		chk("hold_released", chip_reset_req, 32'h0);
		chk("pin_released", ext_reset_n, 32'h1);
		// ----------------------------------------------------------------
		// Reset in mid-run clears enable and flag
		// ----------------------------------------------------------------
		wr(svm_pkg::OFF_STATUS, 32'h4);
		@(posedge pclk);
		chk("irq_before_reset", cpu_irq, 32'h1);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("outputs_in_reset", {ext_reset_n, chip_reset_req, cpu_irq, cmp_enable}, 32'h8);
		presetn <= 1'b1;
		rd(svm_pkg::OFF_STATUS, 32'h0, "status_rerun");
		rd(svm_pkg::OFF_CONFIG, 32'h11, "config_rerun");
		final_report;
	end
endmodule
